// File: rtl/card_host_port.sv
// How it works
// - host grounds mode select for ide mode
// - wait for ready high after reset, memory mode
// - io mode holds region select low once CHP_IDLE is first reached
// - ide mode ties region and write enable high
// - io completion waits for the wait pin high; ide completion is timed by count
`timescale 1ns/1ps
module card_host_port
	import chp_pkg::*;
(
	input  wire logic                  clk,
	input  wire logic                  reset_n,
	input  wire chp_mode_t             mode,
	input  wire logic                  reqValid,
	input  wire logic                  reqWrite,
	input  wire chp_space_t            reqSpace,
	input  wire logic [CHP_ADDR_W-1:0] reqAddr,
	input  wire logic [1:0]            reqLanes,
	input  wire logic [CHP_DATA_W-1:0] reqWData,
	input  wire logic                  cardResetReq,
	output logic                       reqReady,
	output logic                       rspValid,
	output logic [CHP_DATA_W-1:0]      rspRData,
	output logic                       rspWide,
	output logic                       cardReady,
	output logic                       cardIrq,
	output logic                       cardWriteProt,
	output logic                       cardWaitHigh,
	output logic [1:0]                 cardVoltSense,
	output logic [CHP_ADDR_W-1:0]      cardAddr,
	output logic [CHP_DATA_W-1:0]      cardDataOut,
	output logic                       cardDataOe,
	input  wire logic [CHP_DATA_W-1:0] cardDataIn,
	output logic [1:0]                 card_enable_n,
	output logic                       regionSelect_n,
	output logic                       outputEnable_n,
	output logic                       writeEnable_n,
	output logic                       ioReadStrobe_n,
	output logic                       io_write_strobe_n,
	output logic                       cardResetPin,
	input  wire logic                  ready_not_busy,
	input  wire logic                  cardWait_n,
	input  wire logic                  writeProtect,
	input  wire logic                  word_transfer_n,
	input  wire logic [1:0]            voltage_sense_n
);
	typedef enum logic [2:0] {
		CHP_IDLE, CHP_RESET, CHP_INIT, CHP_SETUP, CHP_STROBE, CHP_HOLD
	} chp_state_t;

	chp_state_t                 state;
	logic [CHP_CNT_W-1:0]       count;
	logic                       curWrite;
	chp_space_t                 curSpace;
	logic                       ioSetUp;
	logic [CHP_DATA_W-1:0]      dataSync;
	logic [5:0]                 pinsSync;
	logic                       rdyS, waitS, wpS, wordS_n;
	logic [1:0]                 vsS;

	chp_pin_sync #(.WIDTH(CHP_DATA_W)) u_dataSync (
		.clk     (clk),
		.reset_n (reset_n),
		.pinIn   (cardDataIn),
		.syncOut (dataSync)
	);
	chp_pin_sync #(.WIDTH(6)) u_pinSync (
		.clk     (clk),
		.reset_n (reset_n),
		.pinIn   ({ready_not_busy, cardWait_n, writeProtect,
		            word_transfer_n, voltage_sense_n}),
		.syncOut (pinsSync)
	);
	assign {rdyS, waitS, wpS, wordS_n, vsS} = pinsSync;

	// refuse a request the current mode cannot carry
	function automatic logic legal(input chp_mode_t m, input chp_space_t s);
		case (m)
			CHP_MODE_MEMORY: legal = (s != CHP_SPACE_TASKIO);
			CHP_MODE_IO:     legal = (s != CHP_SPACE_TASKMEM);
			CHP_MODE_IDE:    legal = (s == CHP_SPACE_TASKIO);
			default:         legal = 1'b0;
		endcase
	endfunction : legal

	// io space needs an io-capable mode and a finished reset
	function automatic logic ioOk(input chp_mode_t m, input logic up);
		ioOk = (m != CHP_MODE_MEMORY) && up;
	endfunction : ioOk

	always_ff @(posedge clk)
	begin
		if (!reset_n)
		begin
			state <= CHP_RESET;
			count <= CHP_RESET_LOAD;
		end
		else
		begin
			case (state)
				CHP_IDLE:
				begin
					// a taken request is never dropped for a card reset
					if (reqValid && reqReady)
					begin
						state <= CHP_SETUP;
						count <= CHP_SETUP_LOAD;
					end
					else if (cardResetReq)
					begin
						state <= CHP_RESET;
						count <= CHP_RESET_LOAD;
					end
				end
				CHP_RESET:
				begin
					if (count <= 8'h01)
					begin
						state <= CHP_INIT;
						count <= '0;
					end
					else
						count <= count - 8'h01;
				end
				CHP_INIT:
				begin
					// only memory mode has a usable busy pin
					if (mode != CHP_MODE_MEMORY || rdyS)
						state <= CHP_IDLE;
				end
				CHP_SETUP:
				begin
					if (count <= 8'h01)
					begin
						state <= CHP_STROBE;
						count <= CHP_STROBE_LOAD;
					end
					else
						count <= count - 8'h01;
				end
				CHP_STROBE:
				begin
					// memory mode card never stretches: wait ignored there
					if (count <= 8'h01 &&
					    (waitS || mode != CHP_MODE_IO))
					begin
						state <= CHP_HOLD;
						count <= CHP_HOLD_LOAD;
					end
					else if (count > 8'h01)
						count <= count - 8'h01;
				end
				CHP_HOLD:
				begin
					if (count <= 8'h01)
						state <= CHP_IDLE;
					else
						count <= count - 8'h01;
				end
				default:
					state <= CHP_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk)
	begin
		if (!reset_n)
			ioSetUp <= 1'b0;
		else if (state == CHP_RESET)
			ioSetUp <= 1'b0;
		else if (state == CHP_INIT && mode != CHP_MODE_MEMORY)
			ioSetUp <= 1'b1;
	end

	always_ff @(posedge clk)
	begin
		if (!reset_n)
		begin
			curWrite       <= 1'b0;
			curSpace       <= CHP_SPACE_ATTRIB;
			cardAddr       <= '0;
			cardDataOut    <= '0;
			card_enable_n  <= 2'b11;
			regionSelect_n <= 1'b1;
		end
		else if (state == CHP_IDLE && reqValid && reqReady)
		begin
			curWrite    <= reqWrite;
			curSpace    <= reqSpace;
			cardAddr    <= reqAddr;
			cardDataOut <= reqWData;
			// lanes: 01 even byte, 10 odd byte, 11 word
			case (reqLanes)
				2'b11:   card_enable_n <= (mode == CHP_MODE_IDE) ?
				                          2'b10 : 2'b00;
				2'b10:   card_enable_n <= (mode == CHP_MODE_IDE) ?
				                          2'b10 : 2'b01;
				default: card_enable_n <= 2'b10;
			endcase
			if (mode == CHP_MODE_IDE)
				regionSelect_n <= 1'b1;
			else if (mode == CHP_MODE_IO)
				regionSelect_n <= 1'b0;
			else
				regionSelect_n <= (reqSpace == CHP_SPACE_TASKMEM);
		end
		else if (state == CHP_IDLE)
		begin
			card_enable_n  <= 2'b11;
			regionSelect_n <= (mode != CHP_MODE_IO);
		end
	end

	always_ff @(posedge clk)
	begin
		if (!reset_n)
		begin
			outputEnable_n    <= 1'b1;
			writeEnable_n     <= 1'b1;
			ioReadStrobe_n    <= 1'b1;
			io_write_strobe_n <= 1'b1;
			cardDataOe        <= 1'b0;
		end
		else
		begin
			// ide select shares output enable: held low in ide mode
			outputEnable_n <= (mode == CHP_MODE_IDE) ? 1'b0 :
				!(state == CHP_STROBE && !curWrite &&
				  curSpace != CHP_SPACE_TASKIO);
			writeEnable_n <= (mode == CHP_MODE_IDE) ? 1'b1 :
				!(state == CHP_STROBE && curWrite &&
				  curSpace != CHP_SPACE_TASKIO);
			ioReadStrobe_n <= !(state == CHP_STROBE && !curWrite &&
				curSpace == CHP_SPACE_TASKIO && ioOk(mode, ioSetUp));
			io_write_strobe_n <= !(state == CHP_STROBE && curWrite &&
				curSpace == CHP_SPACE_TASKIO && ioOk(mode, ioSetUp));
			// host drives only writes, so the card owns reads
			cardDataOe <= curWrite &&
				(state == CHP_SETUP || state == CHP_STROBE ||
				 state == CHP_HOLD);
		end
	end

	always_ff @(posedge clk)
	begin
		if (!reset_n)
			cardResetPin <= 1'b1;
		else if (mode == CHP_MODE_IDE)
			cardResetPin <= (state != CHP_RESET);
		else
			cardResetPin <= (state == CHP_RESET);
	end

	always_ff @(posedge clk)
	begin
		if (!reset_n)
		begin
			reqReady <= 1'b0;
			rspValid <= 1'b0;
			rspRData <= '0;
			rspWide  <= 1'b0;
		end
		else
		begin
			// judged against the request now held, never a stale space
			reqReady <= (state == CHP_IDLE) && reqValid && !reqReady &&
				!cardResetReq && legal(mode, reqSpace);
			rspValid <= (state == CHP_STROBE) && count <= 8'h01 &&
				(waitS || mode != CHP_MODE_IO);
			if (state == CHP_STROBE && count <= 8'h01 && !curWrite)
				rspRData <= dataSync;
			if (state == CHP_STROBE && curSpace == CHP_SPACE_TASKIO)
				rspWide <= !wordS_n;
		end
	end

	always_ff @(posedge clk)
	begin
		if (!reset_n)
		begin
			cardReady     <= 1'b0;
			cardIrq       <= 1'b0;
			cardWriteProt <= 1'b0;
			cardWaitHigh  <= 1'b0;
			cardVoltSense <= 2'b00;
		end
		else
		begin
			cardReady     <= (mode == CHP_MODE_MEMORY) && rdyS;
			cardIrq       <= (mode == CHP_MODE_IO)  ? !rdyS :
			                 (mode == CHP_MODE_IDE) ? rdyS : 1'b0;
			cardWriteProt <= (mode == CHP_MODE_MEMORY) && wpS;
			// channel ready floats in ide mode; pull-up reads high
			cardWaitHigh  <= waitS;
			cardVoltSense <= ~vsS;
		end
	end
endmodule : card_host_port

// File: rtl/chp_pkg.sv
package chp_pkg;
	typedef enum logic [1:0] {
		CHP_MODE_MEMORY,
		CHP_MODE_IO,
		CHP_MODE_IDE
	} chp_mode_t;

	typedef enum logic [1:0] {
		CHP_SPACE_ATTRIB,
		CHP_SPACE_TASKMEM,
		CHP_SPACE_TASKIO
	} chp_space_t;

	localparam int CHP_ADDR_W = 11;
	localparam int CHP_DATA_W = 16;

	// strobe timing in cycles of the 100 MHz clock
	localparam int CHP_CLK_NS        = 10;
	localparam int CHP_SETUP_NS      = 70;
	localparam int CHP_STROBE_NS     = 165;
	localparam int CHP_HOLD_NS       = 30;
	localparam int CHP_RESET_NS      = 1000;
	localparam int CHP_SETUP_CYC     = (CHP_SETUP_NS + CHP_CLK_NS - 1) / CHP_CLK_NS;
	localparam int CHP_STROBE_CYC    = (CHP_STROBE_NS + CHP_CLK_NS - 1) / CHP_CLK_NS;
	localparam int CHP_HOLD_CYC      = (CHP_HOLD_NS + CHP_CLK_NS - 1) / CHP_CLK_NS;
	localparam int CHP_RESET_CYC     = (CHP_RESET_NS + CHP_CLK_NS - 1) / CHP_CLK_NS;
	localparam int CHP_CNT_W         = 8;
	localparam logic [CHP_CNT_W-1:0] CHP_SETUP_LOAD  = CHP_CNT_W'(CHP_SETUP_CYC);
	localparam logic [CHP_CNT_W-1:0] CHP_STROBE_LOAD = CHP_CNT_W'(CHP_STROBE_CYC);
	localparam logic [CHP_CNT_W-1:0] CHP_HOLD_LOAD   = CHP_CNT_W'(CHP_HOLD_CYC);
	localparam logic [CHP_CNT_W-1:0] CHP_RESET_LOAD  = CHP_CNT_W'(CHP_RESET_CYC);
endpackage : chp_pkg

// File: rtl/chp_pin_sync.sv
`timescale 1ns/1ps
module chp_pin_sync #(
	parameter int WIDTH = 1
) (
	input  wire logic             clk,
	input  wire logic             reset_n,
	input  wire logic [WIDTH-1:0] pinIn,
	output logic      [WIDTH-1:0] syncOut
);
	logic [WIDTH-1:0] firstStage;

	always_ff @(posedge clk)
	begin
		if (!reset_n)
		begin
			firstStage <= '1;
			syncOut    <= '1;
		end
		else
		begin
			firstStage <= pinIn;
			syncOut    <= firstStage;
		end
	end
endmodule : chp_pin_sync

// File: testbench/chp_chk.sv
`timescale 1ns/1ps
module chp_chk
	import chp_pkg::*;
(
	input wire logic       clk,
	input wire logic       reset_n,
	input wire chp_mode_t  mode,
	input wire logic       reqValid,
	input wire logic       reqReady,
	input wire chp_space_t reqSpace,
	input wire logic [1:0] reqLanes,
	input wire logic       cardReady,
	input wire logic       cardIrq,
	input wire logic       cardResetPin,
	input wire logic [1:0] card_enable_n,
	input wire logic       regionSelect_n,
	input wire logic       outputEnable_n,
	input wire logic       ioReadStrobe_n,
	input wire logic       io_write_strobe_n,
	input wire logic       cardDataOe,
	input wire logic       ready_not_busy
);
	logic take;
	assign take = reqValid && reqReady;
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	mem_iow_a: assert property (mode == CHP_MODE_MEMORY
		|-> io_write_strobe_n) else $error("io write in memory mode");
	io_oe_a: assert property (mode == CHP_MODE_IO && !outputEnable_n
		|-> !regionSelect_n && ioReadStrobe_n) else $error("io mode read");
	busy_hold_a: assert property (mode == CHP_MODE_MEMORY && !cardReady
		|-> !reqReady) else $error("request while busy");
	io_irq_a: assert property (mode == CHP_MODE_IO && $fell(ready_not_busy)
		|-> ##[1:5] cardIrq) else $error("io interrupt missed");
	ide_irq_a: assert property (mode == CHP_MODE_IDE && $rose(ready_not_busy)
		|-> ##[1:5] cardIrq) else $error("ide interrupt missed");
	attr_sel_a: assert property (mode == CHP_MODE_MEMORY && take
		&& reqSpace == CHP_SPACE_ATTRIB |-> ##1 !regionSelect_n)
		else $error("attribute select wrong");
	card_rst_a: assert property (mode != CHP_MODE_IDE && $rose(reset_n)
		|-> cardResetPin [*8]) else $error("card reset too short");
	word_en_a: assert property (mode != CHP_MODE_IDE && take
		&& reqLanes == 2'h3 |-> ##1 card_enable_n == 2'h0)
		else $error("word enables wrong");
	host_drive_a: assert property (!ioReadStrobe_n ||
		(mode != CHP_MODE_IDE && !outputEnable_n) |-> !cardDataOe)
		else $error("host drives data during read");
endmodule : chp_chk
bind card_host_port chp_chk u_chk (.clk, .reset_n, .mode, .reqValid,
	.reqReady, .reqSpace, .reqLanes, .cardReady, .cardIrq, .cardResetPin,
	.card_enable_n, .regionSelect_n, .outputEnable_n, .ioReadStrobe_n,
	.io_write_strobe_n, .cardDataOe, .ready_not_busy);

// File: testbench/chp_card_model.sv
`timescale 1ns/1ps
module chp_card_model
	import chp_pkg::*;
(
	input  wire logic        clk,
	input  wire chp_mode_t   mode,
	input  wire logic        irqReq,
	input  wire logic [1:0]  card_enable_n,
	input  wire logic        regionSelect_n,
	input  wire logic        outputEnable_n,
	input  wire logic        writeEnable_n,
	input  wire logic        ioReadStrobe_n,
	input  wire logic        io_write_strobe_n,
	input  wire logic        cardResetPin,
	input  wire logic [15:0] cardDataOut,
	output logic [15:0]      cardDataIn,
	output logic             ready_not_busy,
	output logic             cardWait_n,
	output logic             writeProtect,
	output logic             word_transfer_n,
	output logic [1:0]       voltage_sense_n
);
	logic [7:0]  busy = '0;
	logic [15:0] lastWr = '0;
	logic        lastRegion = '0;
	int          ioWrites = 0;
	logic        ide, rst, sel, io;
	assign ide = mode == CHP_MODE_IDE;
	assign rst = ide ? !cardResetPin : cardResetPin;
	// ide: both enables low is invalid, data register needs low byte only
	assign sel = ide ? card_enable_n == 2'h2 : card_enable_n != 2'h3;
	assign io = !ioReadStrobe_n || !io_write_strobe_n;
	// each read path has its own word; a released bus matches none
	assign cardDataIn = !sel ? 16'ha55a : !ioReadStrobe_n ? 16'h5aa5
		: !outputEnable_n && !ide ? 16'h3cc3 : 16'ha55a;
	assign ready_not_busy = mode == CHP_MODE_MEMORY ? busy == '0 && !rst
		: ide ? irqReq : !irqReq;
	assign word_transfer_n = !(io && (ide ? sel : card_enable_n == '0));
	// ide channel ready floats; the pull-up makes it read high
	assign cardWait_n = '1;
	assign writeProtect = '0;
	assign voltage_sense_n = 2'h2;
	always @(posedge clk)
		busy <= rst ? 8'h14 : busy - {7'h0, busy != '0};
	always @(posedge io_write_strobe_n)
		if (mode != CHP_MODE_MEMORY && sel && !rst)
		begin
			ioWrites++;
			lastWr = cardDataOut;
		end
	always @(posedge writeEnable_n)
		if (sel && !ide)
		begin
			lastWr = cardDataOut;
			lastRegion = regionSelect_n;
		end
endmodule : chp_card_model

// File: testbench/testbench.sv
`timescale 1ns/1ps
module testbench;
	import chp_pkg::*;
	logic clk = '0, reset_n = '0, reqValid = '0, reqWrite = '0;
	logic cardResetReq = '0, irqReq = '0;
	chp_mode_t mode = CHP_MODE_MEMORY;
	chp_space_t reqSpace = CHP_SPACE_ATTRIB;
	logic [CHP_ADDR_W-1:0] reqAddr = 11'h0a2, cardAddr;
	logic [1:0] reqLanes = 2'h3, cardVoltSense, card_enable_n, voltage_sense_n;
	logic [CHP_DATA_W-1:0] reqWData = '0, rspRData, cardDataOut, cardDataIn;
	logic reqReady, rspValid, rspWide, cardReady, cardIrq, cardWriteProt;
	logic cardWaitHigh, cardDataOe, regionSelect_n, outputEnable_n;
	logic writeEnable_n, ioReadStrobe_n, io_write_strobe_n, cardResetPin;
	logic ready_not_busy, cardWait_n, writeProtect, word_transfer_n;
	int num_errors = 0, cmp_count = 0;
	card_host_port dut (.*);
	chp_card_model card (.*);
	always #5 clk = ~clk;
	task automatic chk(input string what, input logic [15:0] exp, got);
		cmp_count++;
		if (got !== exp)
		begin
			num_errors++;
			$display("unexpected %s: expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic chk1(input string what, input logic exp, got);
		chk(what, {15'h0, exp}, {15'h0, got});
	endtask : chk1
	task automatic start(input chp_mode_t m);
		mode = m;
		reset_n = '0;
		repeat (12) @(posedge clk);
		#1 reset_n = '1;
	endtask : start
	// a refused request waits the full bound, long enough to cover init
	task automatic xfer(input logic w, input chp_space_t s,
		input logic [15:0] d, input logic ok);
		int n;
		n = 0;
		reqValid = '1;
		reqWrite = w;
		reqSpace = s;
		reqWData = d;
		do
		begin
			@(negedge clk);
			n++;
		end while (reqReady !== 1'b1 && n < 400);
		chk1("taken", ok, n < 400);
		@(posedge clk);
		#1 reqValid = '0;
		n = 0;
		while (ok && rspValid !== 1'b1 && n < 60)
		begin
			@(negedge clk);
			n++;
		end
		if (ok)
			chk1("done", 1'b1, n < 60);
		repeat (4) @(posedge clk);
		#1;
	endtask : xfer
	task automatic irq_scn();
		for (int i = 1; i >= 0; i--)
		begin
			irqReq = i[0];
			repeat (6) @(posedge clk);
			#1 chk1("irq", i[0], cardIrq);
		end
	endtask : irq_scn
	task automatic mem_scn();
		start(CHP_MODE_MEMORY);
		xfer(1'b0, CHP_SPACE_ATTRIB, 16'h0, 1'b1);
		chk("read", 16'h3cc3, rspRData);
		chk("addr", 16'h00a2, {5'h0, cardAddr});
		cardResetReq = '1;
		@(posedge clk);
		#1 cardResetReq = '0;
		repeat (3) @(posedge clk);
		#1 chk1("reset pin", 1'b1, cardResetPin);
		xfer(1'b1, CHP_SPACE_TASKMEM, 16'h3c1e, 1'b1);
		chk("write", 16'h3c1e, card.lastWr);
		chk1("task region", 1'b1, card.lastRegion);
		xfer(1'b1, CHP_SPACE_TASKIO, 16'h0f0f, 1'b0);
		chk("io writes", 16'h0, 16'(card.ioWrites));
		chk1("protect", 1'b0, cardWriteProt);
		chk1("wait", 1'b1, cardWaitHigh);
		chk("sense", 16'h1, {14'h0, cardVoltSense});
	endtask : mem_scn
	task automatic io_scn();
		start(CHP_MODE_IO);
		xfer(1'b1, CHP_SPACE_TASKIO, 16'h9669, 1'b1);
		chk("io writes", 16'h1, 16'(card.ioWrites));
		chk("io data", 16'h9669, card.lastWr);
		xfer(1'b0, CHP_SPACE_TASKIO, 16'h0, 1'b1);
		chk1("wide", 1'b1, rspWide);
		chk("io read", 16'h5aa5, rspRData);
		xfer(1'b1, CHP_SPACE_ATTRIB, 16'h1234, 1'b1);
		chk("attr data", 16'h1234, card.lastWr);
		chk1("io region", 1'b0, card.lastRegion);
		xfer(1'b0, CHP_SPACE_ATTRIB, 16'h0, 1'b1);
		chk("attr read", 16'h3cc3, rspRData);
		irq_scn();
	endtask : io_scn
	task automatic ide_scn();
		start(CHP_MODE_IDE);
		repeat (2) @(posedge clk);
		#1 chk1("ide reset pin", 1'b0, cardResetPin);
		chk1("ide select", 1'b0, outputEnable_n);
		chk1("ide write enable", 1'b1, writeEnable_n);
		xfer(1'b0, CHP_SPACE_ATTRIB, 16'h0, 1'b0);
		xfer(1'b0, CHP_SPACE_TASKIO, 16'h0, 1'b1);
		chk1("wide", 1'b1, rspWide);
		chk("read", 16'h5aa5, rspRData);
		xfer(1'b1, CHP_SPACE_TASKIO, 16'h7e81, 1'b1);
		chk("ide data", 16'h7e81, card.lastWr);
		irq_scn();
	endtask : ide_scn
	task automatic close_out();
		$display("comparisons %0d, errors %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : close_out
	initial
	begin
		mem_scn();
		io_scn();
		ide_scn();
		close_out();
	end
	initial
	begin
		#100000;
		num_errors++;
		close_out();
	end
endmodule : testbench
